// file: rtl/blink_gen.sv
`timescale 1ns/100ps
module blink_gen #(
  parameter int ON_STEP = 1_000_000,
  parameter int PER_STEP = 10_000_000
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic [6:0] on_units,
  input wire logic [6:0] per_units,
  output logic drive
);
  // ****************************************
  // Step prescalers and interval counters
  // ****************************************
  logic [31:0] on_pre_reg;
  logic [31:0] per_pre_reg;
  logic [7:0] on_cnt_reg;
  logic [7:0] per_cnt_reg;
  logic drive_reg;
  wire on_tick = (on_pre_reg == 32'(ON_STEP - 1));
  wire per_tick = (per_pre_reg == 32'(PER_STEP - 1));
  // Zero codes run as one step, the least interval
  wire [7:0] on_len = (on_units == 7'h00) ? 8'h01 : {1'b0, on_units};
  wire [7:0] per_len = (per_units == 7'h00) ? 8'h01 : {1'b0, per_units};
  wire per_end = per_tick && (per_cnt_reg >= per_len - 8'h01);
  wire on_end = on_tick && (on_cnt_reg >= on_len - 8'h01);

  // Drive for on-time at each period start, then release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      on_pre_reg <= 32'h0;
      per_pre_reg <= 32'h0;
      on_cnt_reg <= 8'h00;
      per_cnt_reg <= 8'h00;
      drive_reg <= 1'b0;
    end else if (!enable) begin
      on_pre_reg <= 32'h0;
      per_pre_reg <= 32'h0;
      on_cnt_reg <= 8'h00;
      per_cnt_reg <= 8'h00;
      drive_reg <= 1'b1;
    end else begin
      on_pre_reg <= (on_tick || per_end) ? 32'h0 : on_pre_reg + 32'h1;
      per_pre_reg <= per_tick ? 32'h0 : per_pre_reg + 32'h1;
      if (per_end) begin
        per_cnt_reg <= 8'h00;
        on_cnt_reg <= 8'h00;
        drive_reg <= 1'b1;
      end else begin
        if (per_tick) per_cnt_reg <= per_cnt_reg + 8'h01;
        if (on_tick && drive_reg) on_cnt_reg <= on_cnt_reg + 8'h01;
        if (on_end) drive_reg <= 1'b0;
      end
    end
  end
  assign drive = drive_reg;
endmodule

// file: rtl/indicator_blink_and_supply_config.sv
// Contract
// - Indicator one modes: charger, blink, off, on
// - Timing registers override charger per mode bits
// - On-time in 10 ms steps, minimum 10
// - Indicator one period in 100 ms steps
// - Indicator two period in 100 ms steps
// - Indicator two modes: off, blink, off, on
// - Forced fixed frequency blocks pulse skipping
// - Two-bit undervoltage threshold select
// - Supply select picks wait or low-power
// - Sleep enable gates the sleep pin
// - Main discharge while main converter off
// - Main code, strap default, rewritable
// - Core-off bit disables core in low-power
// - Three-bit core voltage code
// - Core code reset follows core strap
// - Low-power core code is 0 plus bits
// - Motor drive bit switches motor transistor
// - Core discharge in wait or low-power off
// - Regulator enable and sleep-off behaviour
`timescale 1ns/100ps
module indicator_blink_and_supply_config #(
  parameter int ON_STEP_CYC = pmic_cfg_pkg::ON_STEP_CYC,
  parameter int PER_STEP_CYC = pmic_cfg_pkg::PER_STEP_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic charger_led_req,
  input wire logic sleep_request_pin,
  input wire logic io_rail_strap_pin,
  input wire logic cpu_rail_strap_pin,
  output logic charge_indicator_pin_oe,
  output logic second_indicator_pin_oe,
  output logic forced_fixed_freq,
  output logic [1:0] undervoltage_threshold_sel,
  output logic wait_mode,
  output logic low_power_mode,
  output logic main_enable,
  output logic main_discharge,
  output logic [1:0] io_rail_code,
  output logic core_enable,
  output logic core_discharge,
  output logic [2:0] cpu_rail_code,
  output logic motor_drive_enable,
  output logic [1:0] regulator_on,
  output logic [1:0] regulator_low_power,
  output logic [1:0] ldo2_code,
  output logic [1:0] ldo1_code
);
  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] indicator1_on_time_reg;
  logic [7:0] indicator1_period_reg;
  logic [7:0] indicator2_on_time_reg;
  logic [7:0] indicator2_period_reg;
  logic [7:0] main_converter_config_reg;
  logic [7:0] core_converter_config_reg;
  logic [7:0] regulator_enable_voltage_reg;
  logic strap_done_reg;

  // Write strobes per register
  wire wr_i1_on = wr_en && (wr_addr == pmic_cfg_pkg::ADDR_IND1_ON);
  wire wr_i1_per = wr_en && (wr_addr == pmic_cfg_pkg::ADDR_IND1_PER);
  wire wr_i2_on = wr_en && (wr_addr == pmic_cfg_pkg::ADDR_IND2_ON);
  wire wr_i2_per = wr_en && (wr_addr == pmic_cfg_pkg::ADDR_IND2_PER);
  wire wr_main = wr_en && (wr_addr == pmic_cfg_pkg::ADDR_MAIN_CFG);
  wire wr_core = wr_en && (wr_addr == pmic_cfg_pkg::ADDR_CORE_CFG);
  wire wr_regs = wr_en && (wr_addr == pmic_cfg_pkg::ADDR_REG_EN);

  // Indicator one on-time and upper mode bit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      indicator1_on_time_reg <= pmic_cfg_pkg::RST_IND;
    end else if (wr_i1_on) begin
      indicator1_on_time_reg <= wr_data;
    end
  end

  // Indicator one period and lower mode bit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      indicator1_period_reg <= pmic_cfg_pkg::RST_IND;
    end else if (wr_i1_per) begin
      indicator1_period_reg <= wr_data;
    end
  end

  // Indicator two on-time and upper mode bit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      indicator2_on_time_reg <= pmic_cfg_pkg::RST_IND;
    end else if (wr_i2_on) begin
      indicator2_on_time_reg <= wr_data;
    end
  end

  // Indicator two period and lower mode bit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      indicator2_period_reg <= pmic_cfg_pkg::RST_IND;
    end else if (wr_i2_per) begin
      indicator2_period_reg <= wr_data;
    end
  end

  // ****************************************
  // Converter config with strap capture
  // ****************************************
  // Straps are sampled on the first edge after reset release; a write in
  // that cycle still wins over the strap value.
  wire [7:0] main_strap = {pmic_cfg_pkg::RST_MAIN_CFG[7:1], io_rail_strap_pin};
  wire [7:0] core_strap = pmic_cfg_pkg::RST_CORE_CFG | (cpu_rail_strap_pin ? pmic_cfg_pkg::RST_CORE_STRAP_MASK : 8'h00);

  // Marks that the straps have been taken once
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done_reg <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
    end
  end

  // Main converter config, write beats strap capture
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      main_converter_config_reg <= pmic_cfg_pkg::RST_MAIN_CFG;
    end else if (wr_main) begin
      main_converter_config_reg <= wr_data;
    end else if (!strap_done_reg) begin
      main_converter_config_reg <= main_strap;
    end
  end

  // Core converter config, write beats strap capture
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_converter_config_reg <= pmic_cfg_pkg::RST_CORE_CFG;
    end else if (wr_core) begin
      core_converter_config_reg <= wr_data;
    end else if (!strap_done_reg) begin
      core_converter_config_reg <= core_strap;
    end
  end

  // Regulator enables, sleep bits and voltage codes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regulator_enable_voltage_reg <= pmic_cfg_pkg::RST_REG_EN;
    end else if (wr_regs) begin
      regulator_enable_voltage_reg <= wr_data;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] rd_next;
  always_comb begin
    case (rd_addr)
      pmic_cfg_pkg::ADDR_IND1_ON: rd_next = indicator1_on_time_reg;
      pmic_cfg_pkg::ADDR_IND1_PER: rd_next = indicator1_period_reg;
      pmic_cfg_pkg::ADDR_IND2_ON: rd_next = indicator2_on_time_reg;
      pmic_cfg_pkg::ADDR_IND2_PER: rd_next = indicator2_period_reg;
      pmic_cfg_pkg::ADDR_MAIN_CFG: rd_next = main_converter_config_reg;
      pmic_cfg_pkg::ADDR_CORE_CFG: rd_next = core_converter_config_reg;
      pmic_cfg_pkg::ADDR_REG_EN: rd_next = regulator_enable_voltage_reg;
      default: rd_next = 8'h00;
    endcase
  end

  // ****************************************
  // Indicator generators
  // ****************************************
  wire [1:0] ind1_mode = {indicator1_on_time_reg[pmic_cfg_pkg::MODE_BIT], indicator1_period_reg[pmic_cfg_pkg::MODE_BIT]};
  wire [1:0] ind2_mode = {indicator2_on_time_reg[pmic_cfg_pkg::MODE_BIT], indicator2_period_reg[pmic_cfg_pkg::MODE_BIT]};
  // Timing fields and blink enables, one entry per indicator
  wire [6:0] on_units [2];
  wire [6:0] per_units [2];
  wire [1:0] blink_en;
  wire [1:0] blink_drive;
  assign on_units[0] = indicator1_on_time_reg[6:0];
  assign per_units[0] = indicator1_period_reg[6:0];
  assign on_units[1] = indicator2_on_time_reg[6:0];
  assign per_units[1] = indicator2_period_reg[6:0];
  assign blink_en[0] = (ind1_mode == pmic_cfg_pkg::MODE_BLINK);
  assign blink_en[1] = (ind2_mode == pmic_cfg_pkg::MODE_BLINK);
  wire ind1_blink = blink_drive[0];
  wire ind2_blink = blink_drive[1];

  // One blink generator per indicator
  generate
    for (genvar g = 0; g < 2; g++) begin : g_blink
      blink_gen #(.ON_STEP(ON_STEP_CYC), .PER_STEP(PER_STEP_CYC)) u_blink (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .enable(blink_en[g]),
        .on_units(on_units[g]),
        .per_units(per_units[g]),
        .drive(blink_drive[g])
      );
    end
  endgenerate

  // Mode selection for the two open-drain pins
  logic ind1_next;
  logic ind2_next;
  always_comb begin
    case (ind1_mode)
      pmic_cfg_pkg::MODE_DEFAULT: ind1_next = charger_led_req;
      pmic_cfg_pkg::MODE_BLINK: ind1_next = ind1_blink;
      pmic_cfg_pkg::MODE_OFF: ind1_next = 1'b0;
      default: ind1_next = 1'b1;
    endcase
    case (ind2_mode)
      pmic_cfg_pkg::MODE_BLINK: ind2_next = ind2_blink;
      pmic_cfg_pkg::MODE_ON: ind2_next = 1'b1;
      default: ind2_next = 1'b0;
    endcase
  end

  // ****************************************
  // Power mode decode
  // ****************************************
  wire [7:0] mc = main_converter_config_reg;
  wire [7:0] cc = core_converter_config_reg;
  wire [7:0] rg = regulator_enable_voltage_reg;
  wire sleep_active = sleep_request_pin && mc[pmic_cfg_pkg::LP_EN_BIT];
  wire wait_next = sleep_active && !mc[pmic_cfg_pkg::SUPPLY_SEL_BIT];
  wire lp_next = sleep_active && mc[pmic_cfg_pkg::SUPPLY_SEL_BIT];
  wire core_off_lp = lp_next && cc[pmic_cfg_pkg::CORE_OFF_BIT];
  wire core_en_next = !wait_next && !core_off_lp;
  wire core_dis_next = cc[pmic_cfg_pkg::CORE_DIS_BIT] && (wait_next || core_off_lp);
  wire main_dis_next = mc[pmic_cfg_pkg::MAIN_DIS_BIT] && wait_next;
  // Low-power code keeps the top bit clear
  wire [2:0] core_code_next = lp_next ?
    {1'b0, cc[pmic_cfg_pkg::CORE_LP_HI_BIT], cc[pmic_cfg_pkg::CORE_LP_LO_BIT]} :
    cc[pmic_cfg_pkg::CORE_CODE_LSB +: 3];
  // Regulator pairs: bit 7/6 for two, bit 3/2 for one
  wire [1:0] reg_en = {rg[7], rg[3]};
  wire [1:0] reg_slp_off = {rg[6], rg[2]};
  wire [1:0] reg_on_next = reg_en & ~({2{lp_next}} & reg_slp_off);
  wire [1:0] reg_lp_next = reg_on_next & {2{lp_next}};

  // Read data, one edge after the address
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_next;
    end
  end

  // Open-drain enables of the two indicator pins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      charge_indicator_pin_oe <= 1'b0;
      second_indicator_pin_oe <= 1'b0;
    end else begin
      charge_indicator_pin_oe <= ind1_next;
      second_indicator_pin_oe <= ind2_next;
    end
  end

  // Settings shared by both converters
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      forced_fixed_freq <= 1'b0;
      undervoltage_threshold_sel <= 2'h1;
    end else begin
      forced_fixed_freq <= mc[pmic_cfg_pkg::FORCED_FIXED_FREQ_BIT];
      undervoltage_threshold_sel <= mc[pmic_cfg_pkg::UNDERVOLTAGE_THRESHOLD_SEL_LSB +: 2];
    end
  end

  // Sleep modes entered through the pin
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_mode <= 1'b0;
      low_power_mode <= 1'b0;
    end else begin
      wait_mode <= wait_next;
      low_power_mode <= lp_next;
    end
  end

  // Main converter controls
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      main_enable <= 1'b0;
      main_discharge <= 1'b0;
      io_rail_code <= 2'h2;
    end else begin
      main_enable <= !wait_next;
      main_discharge <= main_dis_next;
      io_rail_code <= mc[1:0];
    end
  end

  // Core converter controls
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_enable <= 1'b0;
      core_discharge <= 1'b0;
      cpu_rail_code <= 3'h4;
    end else begin
      core_enable <= core_en_next;
      core_discharge <= core_dis_next;
      cpu_rail_code <= core_code_next;
    end
  end

  // Motor transistor
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      motor_drive_enable <= 1'b0;
    end else begin
      motor_drive_enable <= cc[pmic_cfg_pkg::MOTOR_BIT];
    end
  end

  // Regulator on and reduced-power states
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regulator_on <= 2'h0;
      regulator_low_power <= 2'h0;
    end else begin
      regulator_on <= reg_on_next;
      regulator_low_power <= reg_lp_next;
    end
  end

  // Regulator voltage codes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ldo2_code <= 2'h0;
      ldo1_code <= 2'h0;
    end else begin
      ldo2_code <= rg[5:4];
      ldo1_code <= rg[1:0];
    end
  end
endmodule

// file: rtl/pmic_cfg_pkg.sv
package pmic_cfg_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_IND1_ON = 8'h08;
  localparam logic [7:0] ADDR_IND1_PER = 8'h09;
  localparam logic [7:0] ADDR_IND2_ON = 8'h0a;
  localparam logic [7:0] ADDR_IND2_PER = 8'h0b;
  localparam logic [7:0] ADDR_MAIN_CFG = 8'h0c;
  localparam logic [7:0] ADDR_CORE_CFG = 8'h0d;
  localparam logic [7:0] ADDR_REG_EN = 8'h0e;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_BIT = 7;
  localparam int FORCED_FIXED_FREQ_BIT = 7;
  localparam int UNDERVOLTAGE_THRESHOLD_SEL_LSB = 5;
  localparam int SUPPLY_SEL_BIT = 4;
  localparam int LP_EN_BIT = 3;
  localparam int MAIN_DIS_BIT = 2;
  localparam int CORE_OFF_BIT = 7;
  localparam int CORE_CODE_LSB = 4;
  localparam int CORE_LP_HI_BIT = 2;
  localparam int CORE_LP_LO_BIT = 3;
  localparam int MOTOR_BIT = 1;
  localparam int CORE_DIS_BIT = 0;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_IND = 8'h00;
  localparam logic [7:0] RST_MAIN_CFG = 8'h32;
  localparam logic [7:0] RST_CORE_CFG = 8'h48;
  localparam logic [7:0] RST_CORE_STRAP_MASK = 8'h30;
  localparam logic [7:0] RST_REG_EN = 8'h88;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int ON_STEP_MS = 10;
  localparam int PER_STEP_MS = 100;
  localparam int ON_STEP_CYC = CLK_HZ / 1000 * ON_STEP_MS;
  localparam int PER_STEP_CYC = CLK_HZ / 1000 * PER_STEP_MS;
  // ****************************************
  // Indicator modes
  // ****************************************
  typedef enum logic [1:0] {
    MODE_DEFAULT = 2'b00,
    MODE_BLINK = 2'b01,
    MODE_OFF = 2'b10,
    MODE_ON = 2'b11
  } ind_mode_t;
endpackage

// file: testbench/cfg_monitor_monitor.sv
`timescale 1ns/100ps
// Checker on the configuration block's ports
module cfg_monitor (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic sleep_request_pin,
  input wire logic forced_fixed_freq,
  input wire logic [1:0] undervoltage_threshold_sel,
  input wire logic wait_mode,
  input wire logic low_power_mode,
  input wire logic main_enable,
  input wire logic main_discharge,
  input wire logic [1:0] io_rail_code,
  input wire logic core_enable,
  input wire logic core_discharge,
  input wire logic [2:0] cpu_rail_code,
  input wire logic motor_drive_enable,
  input wire logic [1:0] regulator_on,
  input wire logic [1:0] regulator_low_power
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ********
  // Register writes reaching the outputs
  // ********
  sequence s_core_wr;
    wr_en && wr_addr == pmic_cfg_pkg::ADDR_CORE_CFG ##1 !sleep_request_pin;
  endsequence
  sequence s_main_wr;
    wr_en && wr_addr == pmic_cfg_pkg::ADDR_MAIN_CFG ##1 1'b1;
  endsequence
  property p_core_wr;
    s_core_wr |=> cpu_rail_code == $past(wr_data[6:4], 2) && motor_drive_enable == $past(wr_data[1], 2);
  endproperty
  a_core_wr: assert property (p_core_wr) else $error("core write not applied");
  property p_main_wr;
    s_main_wr |=> {forced_fixed_freq, undervoltage_threshold_sel, io_rail_code} ==
      {$past(wr_data[7:5], 2), $past(wr_data[1:0], 2)};
  endproperty
  a_main_wr: assert property (p_main_wr) else $error("main write not applied");
  // ********
  // Mode relations
  // ********
  property p_pin_gate;
    !sleep_request_pin |=> !wait_mode && !low_power_mode;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("mode without pin");
  property p_excl;
    !(wait_mode && low_power_mode);
  endproperty
  a_excl: assert property (p_excl) else $error("wait and low power together");
  property p_wait_off;
    wait_mode |-> !main_enable && !core_enable;
  endproperty
  a_wait_off: assert property (p_wait_off) else $error("converter on in wait");
  property p_main_dis;
    main_discharge |-> wait_mode;
  endproperty
  a_main_dis: assert property (p_main_dis) else $error("main discharge outside wait");
  property p_core_dis;
    core_discharge |-> !core_enable;
  endproperty
  a_core_dis: assert property (p_core_dis) else $error("core discharge while on");
  property p_lp_code;
    low_power_mode |-> !cpu_rail_code[2];
  endproperty
  a_lp_code: assert property (p_lp_code) else $error("low power code top bit set");
  property p_reg;
    (regulator_low_power & ~regulator_on) == 2'b00 && (low_power_mode || regulator_low_power == 2'b00);
  endproperty
  a_reg: assert property (p_reg) else $error("regulator state illegal");
endmodule

// file: testbench/host_model.sv
`timescale 1ns/100ps
// Host side of the register port
module host_model (
  input wire logic ref_clk,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  // Idle port
  initial begin
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    rd_addr = 8'h00;
  end
  // One write strobe, then a quiet edge; data no longer holds its value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge ref_clk);
    wr_en = 1'b0;
    wr_data = ~d;
  endtask
  // Address taken at one edge, data settled before the next falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    rd_addr = a;
    @(negedge ref_clk);
    d = rd_data;
  endtask
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("MISMATCH t=%0t %s", $time, msg); end end
module tb_top;
  localparam int ON_C = 4;
  localparam int PER_C = 40;
  logic ref_clk, arst_n, chg, pin, strap_io, strap_cpu;
  wire wr_en;
  wire [7:0] wr_addr, wr_data, rd_addr, rd_data;
  wire [24:0] outs;
  logic [7:0] rv;
  logic [7:0] m [8:14];
  logic [7:0] adr [9] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h07, 8'h20};
  logic [31:0] lf = 32'hd5ea;
  int err_count, checks, cyc;
  string msg;
  // Clock and cycle ceiling
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  host_model i_host (.ref_clk, .wr_en, .wr_addr, .wr_data, .rd_addr, .rd_data);
  indicator_blink_and_supply_config #(.ON_STEP_CYC(ON_C), .PER_STEP_CYC(PER_C)) i_dut (
    .ref_clk, .arst_n, .wr_en, .wr_addr, .wr_data, .rd_addr, .rd_data, .charger_led_req(chg),
    .sleep_request_pin(pin), .io_rail_strap_pin(strap_io), .cpu_rail_strap_pin(strap_cpu),
    .charge_indicator_pin_oe(outs[24]), .second_indicator_pin_oe(outs[23]), .forced_fixed_freq(outs[22]),
    .undervoltage_threshold_sel(outs[21:20]), .wait_mode(outs[19]), .low_power_mode(outs[18]),
    .main_enable(outs[17]), .main_discharge(outs[16]), .io_rail_code(outs[15:14]), .core_enable(outs[13]),
    .core_discharge(outs[12]), .cpu_rail_code(outs[11:9]), .motor_drive_enable(outs[8]),
    .regulator_on(outs[7:6]), .regulator_low_power(outs[5:4]), .ldo2_code(outs[3:2]), .ldo1_code(outs[1:0]));
  // Reference model of all outputs but rd_data
  function automatic logic [24:0] expv(input logic p, input logic c);
    logic [7:0] a, d, e;
    logic lp, wt;
    a = m[12];
    d = m[13];
    e = m[14];
    lp = p & a[3] & a[4];
    wt = p & a[3] & ~a[4];
    expv = {m[8][7] ? m[9][7] : ~m[9][7] & c, m[10][7] & m[11][7], a[7:5], wt, lp, ~wt, a[2] & wt, a[1:0],
      ~(wt | lp & d[7]), d[0] & (wt | lp & d[7]), lp ? {1'b0, d[2], d[3]} : d[6:4], d[1],
      e[7] & ~(lp & e[6]), e[3] & ~(lp & e[2]), e[7] & lp & ~e[6], e[3] & lp & ~e[2], e[5:4], e[1:0]};
  endfunction
  function automatic logic [7:0] rnd();
    repeat (8) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction
  // Bus helpers and comparisons
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.wr(a, d);
    if (a >= 8'h08 && a <= 8'h0e) m[a] = d;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    i_host.rd(a, rv);
    msg = "read";
    `CHK(rv, (a >= 8'h08 && a <= 8'h0e) ? m[a] : 8'h00)
  endtask
  task automatic cmp_all(input string s);
    repeat (3) @(negedge ref_clk);
    msg = s;
    `CHK(outs, expv(pin, chg))
  endtask
  task automatic mode(input logic [7:0] a, input logic [1:0] md, input logic [6:0] on, input logic [6:0] per);
    wr(a, {md[1], on});
    wr(a + 8'h01, {md[0], per});
  endtask
  task automatic blink(input int ind, input int on, input int per);
    int n;
    n = 0;
    repeat (3) @(negedge ref_clk);
    repeat (2 * per * PER_C) begin
      @(negedge ref_clk);
      n += ((ind == 1 ? outs[24] : outs[23]) === 1'b1);
    end
    msg = "blink";
    `CHK(n, 2 * on * ON_C)
  endtask
  // Reset with the two straps set opposite ways; model takes the strap defaults
  task automatic reset_dut(input logic s);
    arst_n = 1'b0;
    strap_io = s;
    strap_cpu = ~s;
    foreach (m[i]) m[i] = 8'h00;
    m[12] = {7'h19, s};
    m[13] = s ? 8'h48 : 8'h78;
    m[14] = 8'h88;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
  endtask
  task automatic finish_test();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    chg = 1'b1;
    pin = 1'b0;
    reset_dut(1'b1);
    foreach (adr[i]) rd_chk(adr[i]);
    wr(8'h20, 8'h5a);
    rd_chk(8'h20);
    cmp_all("reset");
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      wr(8'h0c, rnd());
      wr(8'h0d, rnd());
      wr(8'h0e, rnd());
      rv = rnd();
      pin = rv[0] | rv[1];
      chg = rv[2];
      cmp_all("random");
      rd_chk(8'h0d);
    end
    $display("test random done");
    pin = 1'b0;
    for (int md = 0; md < 4; md++) begin
      mode(8'h08, 2'(md), 7'd2, 7'd1);
      mode(8'h0a, 2'(md), 7'd3, 7'd2);
      if (md == 1) begin
        blink(1, 2, 1);
        blink(2, 3, 2);
      end else begin
        chg = ~chg;
        cmp_all("mode");
      end
    end
    mode(8'h08, 2'b01, 7'd0, 7'd0);
    blink(1, 1, 1);
    $display("test indicators done");
    reset_dut(1'b0);
    foreach (adr[i]) rd_chk(adr[i]);
    cmp_all("strap");
    $display("test strap done");
    finish_test();
  end
endmodule
bind indicator_blink_and_supply_config cfg_monitor i_mon (.ref_clk, .arst_n, .wr_en, .wr_addr, .wr_data,
  .sleep_request_pin, .forced_fixed_freq, .undervoltage_threshold_sel, .wait_mode, .low_power_mode,
  .main_enable, .main_discharge, .io_rail_code, .core_enable, .core_discharge, .cpu_rail_code,
  .motor_drive_enable, .regulator_on, .regulator_low_power);
